// ### hw/audio_pkg.sv
// Shared constants for the four-channel TDM serial audio link
// Summary of operation
// (RULE1) Single speed bit clock 256x to 512x rate
// (RULE2) Double speed bit clock exactly 256x rate
// (RULE3) Bit clock never faster than master clock
// (RULE4) Channel one MSB at second rise after sync
// (RULE5) Frame sync high one to n-1 bit clocks
// (RULE6) n follows selected master clock ratio setting
// (RULE7) Sample rate 30-50 kHz, double 60-100 kHz; host defaults give 50 MHz / 2048, about 24.4 kHz, in both modes
// (RULE8) Master clock synchronous, 7.68 to 25.6 MHz; MCLK_HZ here is 50 MHz
// (RULE9) Device launches output bits on falling edge
// (RULE10) Device samples input bits on rising edge
// (RULE11) Playback latency 11 frames, double speed 7
// (RULE12) Chip reset low pulse at least 1 ms
// (RULE13) Hold chip reset low until clocks settle
// (RULE14) Count master clocks per frame for ratio
// (RULE15) Slots contiguous, ascending, each MSB first
package audio_pkg;
   localparam int CHANNELS         = 4;
   localparam int SLOT_BITS        = 32;
   localparam int FRAME_BITS       = CHANNELS * SLOT_BITS;
   localparam int RATIO_MIN        = 256;
   localparam int RATIO_MAX        = 512;
   localparam int LAT_SINGLE       = 11;
   localparam int LAT_DOUBLE       = 7;
   localparam int FIFO_DEPTH       = 32;
   localparam int BCLK_DIV         = 8;
   localparam int FS_HIGH_BCLKS    = 1;
   localparam int MCLK_HZ          = 50_000_000;
   localparam int RESET_LOW_MS     = 1;
   localparam int RESET_LOW_CYCLES = (MCLK_HZ / 1000) * RESET_LOW_MS;
endpackage

// ### hw/tdm_link_if.sv
// Serial audio link between host and converter
`timescale 1ns/1ps
interface tdm_link_if;
   logic bclk;
   logic frame_sync;
   logic serial_data_in;
   logic serial_data_out;
   logic reset_n;

   modport host (
      output bclk,
      output frame_sync,
      output serial_data_in,
      output reset_n,
      input  serial_data_out
   );
   modport dev (
      input  bclk,
      input  frame_sync,
      input  serial_data_in,
      input  reset_n,
      output serial_data_out
   );
endinterface

// ### hw/tdm_device.sv
// Converter end of the TDM link with its playback latency FIFO
`timescale 1ns/1ps
module sample_fifo #(
   parameter int W = 128,
   parameter int D = 32
) (
   input  wire logic                 clk_i,       // Clock
   input  wire logic                 rst_i,       // Synchronous reset
   input  wire logic                 in_valid_i,  // Write request
   output logic                      in_ready_o,  // Not full
   input  wire logic [W-1:0]         in_data_i,   // Write data
   output logic                      out_valid_o, // Not empty
   input  wire logic                 out_ready_i, // Read request
   output logic [W-1:0]              out_data_o,  // Head word
   output logic [$clog2(D):0]        count_o      // Words held
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW:0]   wr_ptr;
   logic [AW:0]   rd_ptr;
   logic          do_wr;
   logic          do_rd;

   assign count_o     = wr_ptr - rd_ptr;
   assign in_ready_o  = (count_o != (AW+1)'(D));
   assign out_valid_o = (wr_ptr != rd_ptr);
   assign do_wr       = in_valid_i & in_ready_o;
   assign do_rd       = out_ready_i & out_valid_o;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

module tdm_device #(
   parameter int W = audio_pkg::FRAME_BITS,
   parameter int D = audio_pkg::FIFO_DEPTH
) (
   input  wire logic                 mclk_i,           // Device clock
   input  wire logic                 rst_i,            // Synchronous reset
   tdm_link_if.dev                   link,             // Serial link
   input  wire logic                 speed_dbl_i,      // 1 = double speed
   input  wire logic                 ratio_sel_i,      // Master ratio: 0 = 256x, 1 = 512x
   input  wire logic [W-1:0]         cap_data_i,       // Frame to transmit
   output logic                      cap_take_o,       // Pulse: cap_data_i latched
   output logic [W-1:0]              play_data_o,      // Delayed received frame
   output logic                      play_valid_o,     // Pulse: play_data_o new
   output logic [15:0]               mclk_per_frame_o, // Clocks per frame
   output logic                      fs_width_err_o,   // Last sync pulse too long
   output logic                      ratio_err_o,      // Last frame length illegal
   output logic                      overrun_o         // Sticky: frame dropped
);
   typedef enum logic [2:0] {
      ST_WAIT  = 3'b001,
      ST_ARM   = 3'b010,
      ST_SHIFT = 3'b100
   } rx_state_t;

   localparam int CW = $clog2(W);
   localparam int FW = $clog2(D) + 1;
   localparam logic [CW-1:0] LAST_BIT = CW'(W - 1);

   rx_state_t     state;
   logic [1:0]    bclk_sy;
   logic [1:0]    fs_sy;
   logic [1:0]    sdi_sy;
   logic [1:0]    rstn_sy;
   logic          bclk_d;
   logic          fs_prev;
   logic          link_rst;
   logic          rise;
   logic          fall;
   logic          fs_start;
   logic          fs_end;
   logic [CW-1:0] bit_cnt;
   logic [W-1:0]  rx_shift;
   logic [W-1:0]  tx_shift;
   logic          sdo;
   logic          frame_done;
   logic [9:0]    fs_hi;
   logic [9:0]    bclk_cnt;
   logic [15:0]   mclk_cnt;
   logic          seen_fs;
   logic [9:0]    fs_limit;
   logic          in_ready;
   logic          out_valid;
   logic [W-1:0]  out_data;
   logic [FW-1:0] fifo_cnt;
   logic [FW-1:0] latency;
   logic          pop;

   // Two flops on every pin; a bit clock above mclk_i could not be seen here [RULE3]
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         // Bit clock idles high; matching that level avoids a false rise after reset
         bclk_sy <= 2'h3;
         fs_sy   <= 2'h0;
         sdi_sy  <= 2'h0;
         rstn_sy <= 2'h0;
         bclk_d  <= 1'b1;
      end else begin
         bclk_sy <= {bclk_sy[0], link.bclk};
         fs_sy   <= {fs_sy[0], link.frame_sync};
         sdi_sy  <= {sdi_sy[0], link.serial_data_in};
         rstn_sy <= {rstn_sy[0], link.reset_n};
         bclk_d  <= bclk_sy[1];
      end
   end

   assign link_rst   = rst_i | ~rstn_sy[1];
   assign rise       = bclk_sy[1] & ~bclk_d;
   assign fall       = ~bclk_sy[1] & bclk_d;
   assign fs_start   = rise & fs_sy[1] & ~fs_prev;
   assign fs_end     = rise & ~fs_sy[1] & fs_prev;
   assign frame_done = rise & (state == ST_SHIFT) & (bit_cnt == LAST_BIT);

   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         fs_prev <= 1'b0;
      end else if (rise) begin
         fs_prev <= fs_sy[1];
      end
   end

   // A new sync always restarts framing, even mid-frame
   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         state <= ST_WAIT;
      end else if (fs_start) begin
         state <= ST_ARM;
      end else if (rise) begin
         unique case (state)
            ST_WAIT: begin
               state <= ST_WAIT;
            end
            ST_ARM: begin
               state <= ST_SHIFT; // [RULE4]
            end
            ST_SHIFT: begin
               if (bit_cnt == LAST_BIT) begin
                  state <= ST_WAIT;
               end
            end
         endcase
      end
   end

   // Receive: one bit per rising edge, slots back to back MSB first
   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         bit_cnt  <= '0;
         rx_shift <= '0;
      end else if (rise && state != ST_WAIT && !fs_start) begin
         rx_shift <= {rx_shift[W-2:0], sdi_sy[1]}; // [RULE10] [RULE15]
         bit_cnt  <= (state == ST_ARM) ? CW'(1) : bit_cnt + 1'b1; // [RULE4]
      end
   end

   // Transmit: launched on falling edges, first one lands before the second rise
   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         tx_shift   <= '0;
         sdo        <= 1'b0;
         cap_take_o <= 1'b0;
      end else begin
         cap_take_o <= fs_start;
         if (fs_start) begin
            tx_shift <= cap_data_i;
         end else if (fall && state != ST_WAIT) begin
            sdo      <= tx_shift[W-1]; // [RULE9] [RULE4] [RULE15]
            tx_shift <= {tx_shift[W-2:0], 1'b0};
         end else if (fall) begin
            sdo <= 1'b0;
         end
      end
   end

   assign link.serial_data_out = sdo;

   // Pulse width limit n-1 follows the master clock ratio setting
   assign fs_limit = ratio_sel_i ? 10'(audio_pkg::RATIO_MAX - 1)
                                 : 10'(audio_pkg::RATIO_MIN - 1); // [RULE6]

   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         fs_hi          <= '0;
         fs_width_err_o <= 1'b0;
      end else if (fs_start) begin
         fs_hi <= 10'h001;
      end else if (rise && fs_sy[1] && fs_hi != 10'h3FF) begin
         fs_hi <= fs_hi + 1'b1;
      end else if (fs_end) begin
         fs_width_err_o <= (fs_hi > fs_limit); // [RULE5]
      end
   end

   // Frame length in bit clocks checked against the speed mode
   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         bclk_cnt    <= '0;
         seen_fs     <= 1'b0;
         ratio_err_o <= 1'b0;
      end else if (fs_start) begin
         bclk_cnt <= 10'h001;
         seen_fs  <= 1'b1;
         if (seen_fs) begin
            if (speed_dbl_i) begin
               ratio_err_o <= (bclk_cnt != 10'(audio_pkg::RATIO_MIN)); // [RULE2]
            end else begin
               ratio_err_o <= (bclk_cnt < 10'(audio_pkg::RATIO_MIN)) ||
                              (bclk_cnt > 10'(audio_pkg::RATIO_MAX)); // [RULE1]
            end
         end
      end else if (rise && bclk_cnt != 10'h3FF) begin
         bclk_cnt <= bclk_cnt + 1'b1;
      end
   end

   // Master clocks between sync rises give the clock ratio
   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         mclk_cnt         <= '0;
         mclk_per_frame_o <= '0;
      end else if (fs_start) begin
         mclk_cnt <= 16'h0001;
         if (seen_fs) begin
            mclk_per_frame_o <= mclk_cnt; // [RULE14]
         end
      end else if (mclk_cnt != 16'hFFFF) begin
         mclk_cnt <= mclk_cnt + 1'b1;
      end
   end

   // Frames wait in the FIFO; one leaves per sync once latency frames are held
   assign latency = speed_dbl_i ? FW'(audio_pkg::LAT_DOUBLE) : FW'(audio_pkg::LAT_SINGLE);
   assign pop     = fs_start & out_valid & (fifo_cnt >= latency); // [RULE11]

   sample_fifo #(
      .W (W),
      .D (D)
   ) u_fifo (
      .clk_i       (mclk_i),
      .rst_i       (link_rst),
      .in_valid_i  (frame_done),
      .in_ready_o  (in_ready),
      .in_data_i   ({rx_shift[W-2:0], sdi_sy[1]}),
      .out_valid_o (out_valid),
      .out_ready_i (pop),
      .out_data_o  (out_data),
      .count_o     (fifo_cnt)
   );

   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         play_data_o  <= '0;
         play_valid_o <= 1'b0;
      end else begin
         play_valid_o <= pop;
         if (pop) begin
            play_data_o <= out_data;
         end
      end
   end

   // Only reachable when latency exceeds depth; kept so a drop never goes unseen
   always_ff @(posedge mclk_i) begin
      if (link_rst) begin
         overrun_o <= 1'b0;
      end else if (frame_done && !in_ready) begin
         overrun_o <= 1'b1;
      end
   end
endmodule

// ### hw/tdm_host.sv
// Host end of the TDM link: clock master, frame generator and capture
`timescale 1ns/1ps
module tdm_host #(
   parameter int DIV     = audio_pkg::BCLK_DIV,
   parameter int FRAME   = audio_pkg::RATIO_MIN,
   parameter int FS_HIGH = audio_pkg::FS_HIGH_BCLKS,
   parameter int RST_LOW = audio_pkg::RESET_LOW_CYCLES,
   parameter int W       = audio_pkg::FRAME_BITS
) (
   input  wire logic                 mclk_i,       // Host clock
   input  wire logic                 rst_i,        // Synchronous reset
   tdm_link_if.host                  link,         // Serial link
   input  wire logic [W-1:0]         play_data_i,  // Frame to send
   input  wire logic                 play_valid_i, // play_data_i offered
   output logic                      play_ready_o, // Frame taken this cycle
   output logic [W-1:0]              cap_data_o,   // Received frame
   output logic                      cap_valid_o   // Pulse: cap_data_o new
);
   localparam int DW = $clog2(DIV);
   localparam int RW = $clog2(RST_LOW + 1);

   logic [DW-1:0] div_cnt;
   logic [RW-1:0] rst_cnt;
   logic          run;
   logic          bclk;
   logic          fall_evt;
   logic [9:0]    pos;
   logic [9:0]    next_pos;
   logic          fs;
   logic          sdi;
   logic [W-1:0]  tx_shift;
   logic [W-1:0]  rx_shift;
   logic [1:0]    sdo_sy;

   // Chip reset held low for the full minimum after our own reset [RULE12] [RULE13]
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rst_cnt <= '0;
      end else if (!run) begin
         rst_cnt <= rst_cnt + 1'b1;
      end
   end
   assign run = (rst_cnt == RW'(RST_LOW));

   // DIV of two or more keeps the bit clock at or below the master clock [RULE3]
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         bclk    <= 1'b1;
      end else begin
         div_cnt <= (div_cnt == DW'(DIV - 1)) ? '0 : div_cnt + 1'b1; // [RULE8]
         if (div_cnt == DW'(DIV / 2 - 1)) begin
            bclk <= 1'b0;
         end else if (div_cnt == DW'(DIV - 1)) begin
            bclk <= 1'b1;
         end
      end
   end

   assign fall_evt     = run & (div_cnt == DW'(DIV / 2 - 1));
   // Sample rate is mclk_i / (DIV * FRAME); both must be set to keep it in band
   assign next_pos     = (pos == 10'(FRAME - 1)) ? 10'h000 : pos + 1'b1; // [RULE7]
   assign play_ready_o = fall_evt & (next_pos == 10'h000);

   // Everything changes with the falling edge; bit j goes out at position j+1
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pos      <= 10'(FRAME - 1);
         fs       <= 1'b0;
         sdi      <= 1'b0;
         tx_shift <= '0;
      end else if (fall_evt) begin
         pos <= next_pos;
         fs  <= (next_pos < 10'(FS_HIGH)); // [RULE5]
         if (next_pos == 10'h000) begin
            tx_shift <= play_valid_i ? play_data_i : '0;
            sdi      <= 1'b0;
         end else if (next_pos <= 10'(W)) begin
            sdi      <= tx_shift[W-1]; // [RULE4] [RULE15] [RULE10]
            tx_shift <= {tx_shift[W-2:0], 1'b0};
         end else begin
            sdi <= 1'b0;
         end
      end
   end

   // Returned data lags by the far synchronisers, so it is read one bit later
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sdo_sy      <= 2'h0;
         rx_shift    <= '0;
         cap_data_o  <= '0;
         cap_valid_o <= 1'b0;
      end else begin
         sdo_sy      <= {sdo_sy[0], link.serial_data_out};
         cap_valid_o <= 1'b0;
         if (fall_evt && next_pos >= 10'h002 && next_pos <= 10'(W + 1)) begin
            rx_shift <= {rx_shift[W-2:0], sdo_sy[1]}; // [RULE9]
            if (next_pos == 10'(W + 1)) begin
               cap_data_o  <= {rx_shift[W-2:0], sdo_sy[1]};
               cap_valid_o <= 1'b1;
            end
         end
      end
   end

   assign link.bclk           = bclk;
   assign link.frame_sync     = fs;
   assign link.serial_data_in = sdi;
   assign link.reset_n        = run;
endmodule

// ### test/tdm_link_props.sv
// Property checker watching the TDM link between host and device
`timescale 1ns/1ps
module tdm_link_props #(
   parameter int FRAME   = 256,
   parameter int DIV     = 8,
   parameter int RST_LOW = 20
) (
   input wire logic mclk_i,          // Shared clock
   input wire logic rst_i,           // Synchronous reset
   input wire logic bclk,            // Bit clock
   input wire logic frame_sync,      // Frame start
   input wire logic serial_data_in,  // Host to device data
   input wire logic serial_data_out, // Device to host data
   input wire logic reset_n          // Chip reset, active low
);
   int   fcnt;
   int   lowcnt;
   logic seen;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // The first frame after reset has no earlier sync to measure from
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         fcnt <= 0;
         seen <= 1'b0;
      end else if ($rose(frame_sync)) begin
         fcnt <= 1;
         seen <= 1'b1;
      end else begin
         fcnt <= fcnt + 1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || reset_n) begin
         lowcnt <= 0;
      end else begin
         lowcnt <= lowcnt + 1;
      end
   end

   sync_on_fall_a: assert property
      ($rose(frame_sync) |-> !bclk)
      else $error("frame sync rose while bit clock high");
   // Eight clocks make one bit period at the divider used here
   sync_width_a: assert property
      ($rose(frame_sync) |-> frame_sync[*8] ##1 !frame_sync)
      else $error("frame sync width not one bit period");
   frame_len_a: assert property
      ($rose(frame_sync) && seen |-> fcnt == FRAME * DIV)
      else $error("frame length wrong");
   bclk_rate_a: assert property
      ($changed(bclk) |=> $stable(bclk)[*3])
      else $error("bit clock half period too short");
   sdi_setup_a: assert property
      ($changed(serial_data_in) |-> (!bclk)[*3])
      else $error("input data changed near rising bit clock");
   sdo_launch_a: assert property
      ($changed(serial_data_out) |-> !bclk)
      else $error("output data changed while bit clock high");
   sync_slot_a: assert property
      (frame_sync |-> !serial_data_in && !serial_data_out)
      else $error("data bit driven in the sync slot");
   quiet_reset_a: assert property
      (!reset_n |-> !frame_sync && !serial_data_in)
      else $error("link active while chip reset low");
   reset_hold_a: assert property
      ($rose(reset_n) |-> lowcnt >= RST_LOW)
      else $error("chip reset released too early");

   reset_done_c: cover property ($rose(reset_n));
   frame_c: cover property ($rose(frame_sync) && seen);
   sdo_data_c: cover property ($rose(serial_data_out));
endmodule

// ### test/audio_serial_port_framing_tb.sv
// Self-checking bench for the TDM host and device pair
`timescale 1ns/1ps
module audio_serial_port_framing_tb;
   localparam int           RST_LOW = 20;
   localparam logic [127:0] CAP     = 128'hC001_0001_4002_0002_2003_0003_9004_0004;
   logic               mclk_i;
   logic               rst_i      = 1'b1;
   logic               speed_dbl  = 1'b0;
   logic               ratio_sel  = 1'b0;
   logic               speed2     = 1'b0;
   logic               ratio2     = 1'b0;
   logic [127:0]       play_data  = '0;
   logic               play_ready;
   logic [127:0]       cap_data_h;
   logic               cap_valid_h;
   logic [127:0]       play_out;
   logic               play_out_valid;
   logic [15:0]        per_frame;
   logic [15:0]        per_frame2;
   logic               width_err;
   logic               width_err2;
   logic               ratio_err;
   logic               ratio_err2;
   logic               overrun;
   logic               cap_take;
   int                 n_mismatch = 0;
   int                 num_checks = 0;
   int                 n_takes    = 0;
   int                 cycles     = 0;
   logic [127:0]       sent[$];

   tdm_link_if link ();
   tdm_link_if link2 ();
   // Second link carries hand-made frames, some of which break the timing on purpose
   assign link2.serial_data_in = 1'b0;
   assign link2.reset_n = 1'b1;

   tdm_host #(.RST_LOW(RST_LOW)) u_tdm_host (
      .mclk_i(mclk_i), .rst_i(rst_i), .link(link.host), .play_data_i(play_data),
      .play_valid_i(1'b1), .play_ready_o(play_ready), .cap_data_o(cap_data_h),
      .cap_valid_o(cap_valid_h));
   tdm_device u_tdm_device (
      .mclk_i(mclk_i), .rst_i(rst_i), .link(link.dev), .speed_dbl_i(speed_dbl),
      .ratio_sel_i(ratio_sel), .cap_data_i(CAP), .cap_take_o(cap_take), .play_data_o(play_out),
      .play_valid_o(play_out_valid), .mclk_per_frame_o(per_frame),
      .fs_width_err_o(width_err), .ratio_err_o(ratio_err), .overrun_o(overrun));
   tdm_device u_tdm_device2 (
      .mclk_i(mclk_i), .rst_i(rst_i), .link(link2.dev), .speed_dbl_i(speed2),
      .ratio_sel_i(ratio2), .cap_data_i('0), .cap_take_o(), .play_data_o(),
      .play_valid_o(), .mclk_per_frame_o(per_frame2), .fs_width_err_o(width_err2),
      .ratio_err_o(ratio_err2), .overrun_o());
   tdm_link_props #(.RST_LOW(RST_LOW)) u_tdm_link_props (
      .mclk_i(mclk_i), .rst_i(rst_i), .bclk(link.bclk), .frame_sync(link.frame_sync),
      .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
      .reset_n(link.reset_n));

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   // Every offered frame is taken, so the queue index is the frame number
   always @(posedge mclk_i) begin
      if (rst_i) begin
         sent.delete();
         n_takes = 0;
      end else if (play_ready) begin
         sent.push_back(play_data);
         n_takes++;
      end
   end
   always @(negedge mclk_i) begin
      play_data <= {8'h81, 24'(n_takes), 8'h42, 24'(n_takes), 8'h23, 24'(n_takes), 8'h14,
                    24'(n_takes)};
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         $display("timeout after %0d cycles", cycles);
         conclude();
      end
   end

   task automatic check(string what, logic [127:0] exp, logic [127:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset();
      rst_i = 1'b1;
      repeat (6) @(negedge mclk_i);
      rst_i = 1'b0;
   endtask

   task automatic test_wire();
      logic [127:0] exp_in;
      logic [127:0] got_in;
      logic [127:0] got_out;
      @(posedge link.frame_sync);
      @(posedge link.bclk);
      exp_in = sent[$];
      for (int b = 127; b >= 0; b--) begin
         @(posedge link.bclk);
         got_in[b] = link.serial_data_in;
         got_out[b] = link.serial_data_out;
      end
      check("sdi bits", exp_in, got_in);
      check("sdo bits", CAP, got_out);
      for (int i = 0; i < 400 && cap_valid_h !== 1'b1; i++) @(negedge mclk_i);
      check("cap valid", 128'(1), 128'(cap_valid_h));
      @(negedge mclk_i);
      check("cap pulse", 128'(0), 128'(cap_valid_h));
      check("capture", CAP, cap_data_h);
      $display("wire test done");
   endtask

   task automatic test_latency(int lat);
      int pops;
      pops = 0;
      check("play idle", 128'(0), play_out);
      for (int i = 0; i < 40000 && pops < 2; i++) begin
         @(negedge mclk_i);
         if (play_out_valid === 1'b1) begin
            check("play data", sent[pops], play_out);
            check("latency", 128'(lat + 1), 128'(n_takes - pops));
            check("take with pop", 128'(1), 128'(cap_take));
            @(negedge mclk_i);
            check("play pulse", 128'(0), 128'(play_out_valid));
            check("play holds", sent[pops], play_out);
            pops++;
         end
      end
      check("pops", 128'(2), 128'(pops));
      check("clocks per frame", 128'(2048), {112'h0, per_frame});
      check("flags", 128'(0), {125'h0, width_err, ratio_err, overrun});
      $display("latency test %0d done", lat);
   endtask

   // Bit clock at 160 ns, edges on host clock falling edges, still between frames
   task automatic bad_frame(int len, int hi);
      for (int p = 0; p < len; p++) begin
         link2.bclk = 1'b0;
         link2.frame_sync = (p < hi);
         #80;
         link2.bclk = 1'b1;
         #80;
      end
   endtask

   task automatic test_errors();
      bad_frame(600, 300);
      bad_frame(600, 300);
      #100;
      check("long sync", 128'(1), 128'(width_err2));
      check("long frame", 128'(1), 128'(ratio_err2));
      check("frame clocks", 128'(4800), {112'h0, per_frame2});
      ratio2 = 1'b1;
      bad_frame(512, 300);
      #100;
      check("sync under 512", 128'(0), 128'(width_err2));
      bad_frame(256, 1);
      #100;
      check("single 512", 128'(0), 128'(ratio_err2));
      speed2 = 1'b1;
      bad_frame(512, 1);
      bad_frame(256, 1);
      #100;
      check("double 512", 128'(1), 128'(ratio_err2));
      bad_frame(256, 1);
      #100;
      check("double 256", 128'(0), 128'(ratio_err2));
      $display("error test done");
   endtask

   initial begin
      link2.bclk = 1'b1;
      link2.frame_sync = 1'b0;
      do_reset();
      test_wire();
      test_latency(audio_pkg::LAT_SINGLE);
      speed_dbl = 1'b1;
      ratio_sel = 1'b1;
      do_reset();
      test_latency(audio_pkg::LAT_DOUBLE);
      test_errors();
      conclude();
   end
endmodule
